// File: rtl/osc_ctl_map.vh
// register offsets, field positions, reset values and timing counts for the oscillator control block
// assumes a plain word-addressed register port with 8-bit data
`ifndef OSC_CTL_MAP_VH
`define OSC_CTL_MAP_VH

`define OSC_ADDR_W          3
`define OSC_ADDR_CONTROL    3'h0
`define OSC_ADDR_STATUS     3'h1
`define OSC_ADDR_IRQ_STAT   3'h2
`define OSC_ADDR_IRQ_MASK   3'h3
`define OSC_ADDR_TUNE       3'h4

`define OSC_CONTROL_RESET   8'h38
`define OSC_CONTROL_WMASK   8'hFB
`define OSC_TUNE_WMASK      8'h3F

`define OSC_BIT_PLLEN       7
`define OSC_INTERNAL_FREQUENCY_SELECT_HI         6
`define OSC_INTERNAL_FREQUENCY_SELECT_LO         3
`define OSC_SCS_HI          1
`define OSC_SCS_LO          0

`define OSC_ST_TMR_RDY      7
`define OSC_ST_PLL_RDY      6
`define OSC_ST_CONFIG_CLK   5

`define OSC_IRQ_FAIL        0
`define OSC_IRQ_SWITCHED    1
`define OSC_IRQ_W           2

`define OSC_SCS_CONFIG      2'h0
`define OSC_SCS_TIMER       2'h1

`define OSC_MODE_W          3
`define OSC_MODE_LP         3'h0
`define OSC_MODE_XT         3'h1
`define OSC_MODE_HS         3'h2
`define OSC_MODE_EXTCLK     3'h3
`define OSC_MODE_INTOSC     3'h4
`define OSC_MODE_INTOSCIO   3'h5
`define OSC_MODE_RCCLK      3'h6
`define OSC_MODE_RCIO       3'h7

`define OSC_OST_COUNT       11'd1024
`define OSC_SAMPLE_DIV      7'd64
`define OSC_SAMPLE_HALF     7'd32
`define OSC_PLL_LOCK_EDGES  8'hFF

`endif

// File: rtl/osc_ctl_sync.v
// two flop synchroniser with a rising and falling edge pulse taken after the second flop
// assumes the pin is asynchronous to sys_clk and much slower than it
`timescale 1ns/1ns
`default_nettype none
module osc_ctl_sync (
    input  wire sys_clk,
    input  wire rstn,
    input  wire pinIn,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_r;
    reg sync_r;
    reg prev_r;

    always @(posedge sys_clk) begin
        if (!rstn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pinIn;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
    assign fall  = ~sync_r & prev_r;
endmodule
`default_nettype wire

// File: rtl/osc_ctl_top.v
// oscillator control, status flags, start-up timer and fail-safe clock monitor
// assumes oscillator pins are slow asynchronous levels sampled by sys_clk (250 MHz)
`timescale 1ns/1ns
`default_nettype none
`include "osc_ctl_map.vh"
module osc_ctl_top (
    input  wire                   sys_clk,
    input  wire                   rstn,
    input  wire [`OSC_ADDR_W-1:0] regAddr,
    input  wire [7:0]             regWdata,
    input  wire                   regWrite,
    input  wire                   regRead,
    output reg  [7:0]             regRdata,
    input  wire [`OSC_MODE_W-1:0] configuredMode,
    input  wire                   failSafeEnable,
    input  wire                   twoSpeedEnable,
    input  wire                   configPllEnable,
    input  wire                   sleepEnter,
    input  wire                   wakeUp,
    input  wire                   timerOscEnable,
    input  wire                   extOscPin,
    input  wire                   lowFreqOscPin,
    input  wire                   timerOscPin,
    input  wire                   highFreqReadyPin,
    input  wire                   highFreqLockedPin,
    input  wire                   highFreqStablePin,
    input  wire                   mediumFreqReadyPin,
    input  wire                   lowFreqReadyPin,
    input  wire                   pllLockedPin,
    output reg                    sleeping,
    output reg  [1:0]             clockSource,
    output reg                    clockFromHighFreq,
    output reg  [3:0]             internalFrequency,
    output reg                    pllEnable,
    output reg  [5:0]             tuneValue,
    output wire                   irq
);
    localparam SRC_CONFIG = 2'h0;
    localparam SRC_TIMER  = 2'h1;
    localparam SRC_INTERN = 2'h2;

    localparam ST_IDLE    = 4'h1;
    localparam ST_COUNT   = 4'h2;
    localparam ST_RUN     = 4'h4;
    localparam ST_FAILED  = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // codes 0001 and 0011 are duplicates made from the high oscillator
    function fromHighFreq;
        input [3:0] code;
        begin
            fromHighFreq = (code == 4'h1) | (code == 4'h3) | code[3];
        end
    endfunction

    // crystal modes need the start-up timer; external clock and RC do not
    function needsTimer;
        input [`OSC_MODE_W-1:0] mode;
        begin
            needsTimer = (mode == `OSC_MODE_LP) | (mode == `OSC_MODE_XT) | (mode == `OSC_MODE_HS);
        end
    endfunction

    function isInternalMode;
        input [`OSC_MODE_W-1:0] mode;
        begin
            isInternalMode = (mode == `OSC_MODE_INTOSC) | (mode == `OSC_MODE_INTOSCIO);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    wire extFall;
    wire lowRise;
    wire timerRise;
    wire hfReadyS;
    wire hfLockS;
    wire hfStableS;
    wire mfReadyS;
    wire lfReadyS;
    wire pllLockS;
    wire timerLevel;

    osc_ctl_sync uExt (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (extOscPin),
        .level   (),
        .rise    (),
        .fall    (extFall));
    osc_ctl_sync uLow (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (lowFreqOscPin),
        .level   (),
        .rise    (lowRise),
        .fall    ());
    osc_ctl_sync uTmr (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (timerOscPin),
        .level   (timerLevel),
        .rise    (timerRise),
        .fall    ());
    osc_ctl_sync uHfr (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (highFreqReadyPin),
        .level   (hfReadyS),
        .rise    (),
        .fall    ());
    osc_ctl_sync uHfl (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (highFreqLockedPin),
        .level   (hfLockS),
        .rise    (),
        .fall    ());
    osc_ctl_sync uHfs (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (highFreqStablePin),
        .level   (hfStableS),
        .rise    (),
        .fall    ());
    osc_ctl_sync uMfr (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (mediumFreqReadyPin),
        .level   (mfReadyS),
        .rise    (),
        .fall    ());
    osc_ctl_sync uLfr (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (lowFreqReadyPin),
        .level   (lfReadyS),
        .rise    (),
        .fall    ());
    osc_ctl_sync uPll (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pinIn   (pllLockedPin),
        .level   (pllLockS),
        .rise    (),
        .fall    ());

    ////////////////////////////////////////////////////////////////////////////
    // control and tuning registers

    reg  [7:0] control_r;
    reg  [7:0] tune_r;
    reg  [`OSC_IRQ_W-1:0] irqStat_r;
    reg  [`OSC_IRQ_W-1:0] irqMask_r;
    wire [1:0] selField = control_r[`OSC_SCS_HI:`OSC_SCS_LO];
    wire ctlWrite = regWrite & (regAddr == `OSC_ADDR_CONTROL);
    wire [7:0] ctlNext = regWdata & `OSC_CONTROL_WMASK;
    wire selChange = ctlWrite & (ctlNext[`OSC_SCS_HI:`OSC_SCS_LO] != selField);

    always @(posedge sys_clk) begin
        if (!rstn) begin
            control_r <= `OSC_CONTROL_RESET;
            tune_r    <= 8'h00;
            irqMask_r <= {`OSC_IRQ_W{1'b0}};
        end else if (regWrite) begin
            if (regAddr == `OSC_ADDR_CONTROL)
                control_r <= ctlNext;
            if (regAddr == `OSC_ADDR_TUNE)
                tune_r <= regWdata & `OSC_TUNE_WMASK;
            if (regAddr == `OSC_ADDR_IRQ_MASK)
                irqMask_r <= regWdata[`OSC_IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sleep state

    always @(posedge sys_clk) begin
        if (!rstn)
            sleeping <= 1'b0;
        else if (sleepEnter)
            sleeping <= 1'b1;
        else if (wakeUp)
            sleeping <= 1'b0;
    end

    wire wakeEvent = sleeping & wakeUp & ~sleepEnter;

    ////////////////////////////////////////////////////////////////////////////
    // fail-safe sample clock: low oscillator divided by 64

    reg  [6:0] sampleDiv_r;
    reg        sampleHigh_r;
    reg        edgeSeen_r;
    wire       sampleRise = lowRise & (sampleDiv_r == `OSC_SAMPLE_DIV - 7'd1);
    wire       sampleHalf = lowRise & (sampleDiv_r == `OSC_SAMPLE_HALF - 7'd1);

    always @(posedge sys_clk) begin
        if (!rstn) begin
            sampleDiv_r  <= 7'h00;
            sampleHigh_r <= 1'b0;
        end else if (lowRise) begin
            sampleDiv_r  <= sampleRise ? 7'h00 : sampleDiv_r + 7'd1;
            if (sampleRise | sampleHalf)
                sampleHigh_r <= sampleRise;
        end
    end

    // latch set by an external falling edge, cleared at a sample rising edge with no falling edge in that cycle
    always @(posedge sys_clk) begin
        if (!rstn)
            edgeSeen_r <= 1'b0;
        else if (extFall)
            edgeSeen_r <= 1'b1;
        else if (sampleRise)
            edgeSeen_r <= 1'b0;
    end

    // a whole high half of the sample clock passed with no falling edge
    wire missedEdge = sampleHalf & sampleHigh_r & ~edgeSeen_r & ~extFall;

    ////////////////////////////////////////////////////////////////////////////
    // start-up timer and clock switch state machine

    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg  [10:0] ostCount_r;
    reg         configClk_r;
    wire        monitorOn  = failSafeEnable & ~isInternalMode(configuredMode) & ~sleeping;
    wire        timed      = needsTimer(configuredMode);
    wire        twoSpeed   = twoSpeedEnable | failSafeEnable;
    wire        ostTick    = (selField == `OSC_SCS_TIMER) ? timerRise : extFall;
    wire        ostDone    = ostTick & (ostCount_r == `OSC_OST_COUNT - 11'd1);
    wire        restart    = wakeEvent | selChange | sleepEnter;
    wire        extSelected = (selField == `OSC_SCS_CONFIG) | (selField == `OSC_SCS_TIMER);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:   state_nxt = sleeping ? ST_IDLE
                                 : (timed | (selField == `OSC_SCS_TIMER)) ? ST_COUNT : ST_RUN;
            ST_COUNT:  state_nxt = ostDone ? ST_RUN : ST_COUNT;
            ST_RUN:    state_nxt = (monitorOn & extSelected & missedEdge) ? ST_FAILED : ST_RUN;
            ST_FAILED: state_nxt = ST_FAILED;
            default:   state_nxt = ST_IDLE;
        endcase
        if (restart)
            state_nxt = ST_IDLE;
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            state_r    <= ST_IDLE;
            ostCount_r <= 11'd0;
        end else begin
            state_r <= state_nxt;
            if (state_r != ST_COUNT || restart)
                ostCount_r <= 11'd0;
            else if (ostTick)
                ostCount_r <= ostCount_r + 11'd1;
        end
    end

    wire failed  = (state_r == ST_FAILED);
    wire onExt   = (state_r == ST_RUN) & extSelected;

    ////////////////////////////////////////////////////////////////////////////
    // clock source selection outputs

    always @(posedge sys_clk) begin
        if (!rstn) begin
            clockSource       <= SRC_INTERN;
            configClk_r       <= 1'b0;
            clockFromHighFreq <= 1'b0;
            internalFrequency <= 4'h0;
            pllEnable         <= 1'b0;
            tuneValue         <= 6'h00;
        end else begin
            internalFrequency <= control_r[`OSC_INTERNAL_FREQUENCY_SELECT_HI:`OSC_INTERNAL_FREQUENCY_SELECT_LO];
            clockFromHighFreq <= fromHighFreq(control_r[`OSC_INTERNAL_FREQUENCY_SELECT_HI:`OSC_INTERNAL_FREQUENCY_SELECT_LO]);
            pllEnable         <= configPllEnable | control_r[`OSC_BIT_PLLEN];
            tuneValue         <= tune_r[5:0];
            configClk_r       <= onExt & (selField == `OSC_SCS_CONFIG);
            if (selField[1] | failed)
                clockSource <= SRC_INTERN;
            else if (onExt)
                clockSource <= selField[0] ? SRC_TIMER : SRC_CONFIG;
            else if (twoSpeed | ~timed)
                clockSource <= SRC_INTERN;
            else
                clockSource <= SRC_CONFIG;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over a write-one clear

    reg  failed_q;
    reg  switched_q;
    wire failRise     = failed & ~failed_q;
    wire switchedRise = configClk_r & ~switched_q;
    wire [`OSC_IRQ_W-1:0] irqSet = {switchedRise, failRise};
    wire [`OSC_IRQ_W-1:0] irqClr = (regWrite & (regAddr == `OSC_ADDR_IRQ_STAT)) ?
                                   regWdata[`OSC_IRQ_W-1:0] : {`OSC_IRQ_W{1'b0}};

    always @(posedge sys_clk) begin
        if (!rstn) begin
            irqStat_r  <= {`OSC_IRQ_W{1'b0}};
            failed_q   <= 1'b0;
            switched_q <= 1'b0;
        end else begin
            irqStat_r  <= (irqStat_r & ~irqClr) | irqSet;
            failed_q   <= failed;
            switched_q <= configClk_r;
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

    ////////////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after the strobe

    // pll ready only while the pll is requested; timer ready needs its enable
    wire [7:0] statusWord = {timerOscEnable & timerLevel, pllEnable & pllLockS, configClk_r,
                             hfReadyS, hfLockS, mfReadyS, lfReadyS, hfStableS};

    always @(posedge sys_clk) begin
        if (!rstn)
            regRdata <= 8'h00;
        else if (regRead) begin
            case (regAddr)
                `OSC_ADDR_CONTROL:  regRdata <= control_r;
                `OSC_ADDR_STATUS:   regRdata <= statusWord;
                `OSC_ADDR_IRQ_STAT: regRdata <= {6'h00, irqStat_r};
                `OSC_ADDR_IRQ_MASK: regRdata <= {6'h00, irqMask_r};
                `OSC_ADDR_TUNE:     regRdata <= tune_r;
                default:            regRdata <= 8'h00;
            endcase
        end else
            regRdata <= 8'h00;
    end
endmodule
`default_nettype wire

// File: dv/osc_ctl_properties.sv
// port-level assertions for the oscillator control block
// assumes it is bound into osc_ctl_top, one sys_clk domain, rstn synchronous active low
`timescale 1ns/1ns
`default_nettype none
`include "osc_ctl_map.vh"
module osc_ctl_properties (
    input wire logic                   sys_clk,
    input wire logic                   rstn,
    input wire logic [`OSC_ADDR_W-1:0] regAddr,
    input wire logic [7:0]             regWdata,
    input wire logic                   regWrite,
    input wire logic                   regRead,
    input wire logic [7:0]             regRdata,
    input wire logic [`OSC_MODE_W-1:0] configuredMode,
    input wire logic                   sleepEnter,
    input wire logic                   wakeUp,
    input wire logic                   sleeping,
    input wire logic [1:0]             clockSource,
    input wire logic                   clockFromHighFreq,
    input wire logic [3:0]             internalFrequency,
    input wire logic [5:0]             tuneValue,
    input wire logic                   irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // shadow of the mask: irq may only rise with a mask bit open
    logic [1:0] maskCopy_r;
    wire  [3:0] wrFreq = regWdata[6:3];
    wire  [5:0] wrTune = regWdata[5:0];
    always @(posedge sys_clk) begin
        if (!rstn)
            maskCopy_r <= 2'h0;
        else if (regWrite && regAddr == `OSC_ADDR_IRQ_MASK)
            maskCopy_r <= regWdata[1:0];
    end
    ////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!regRead |=> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (regRead && regAddr > `OSC_ADDR_TUNE |=> regRdata == 8'h00)
        else $error("unmapped index returned data");
    ctl_bit2_a: assert property (regRead && regAddr == `OSC_ADDR_CONTROL |=> !regRdata[2])
        else $error("control bit 2 read as one");
    tune_hi_a: assert property (regRead && regAddr == `OSC_ADDR_TUNE |=> regRdata[7:6] == 2'h0)
        else $error("tune upper bits read as one");
    hf_map_a: assert property (clockFromHighFreq == (internalFrequency == 4'h1 ||
        internalFrequency == 4'h3 || internalFrequency[3])) else $error("high oscillator source wrong");
    freq_copy_a: assert property (regWrite && regAddr == `OSC_ADDR_CONTROL |->
        ##2 internalFrequency == $past(wrFreq, 2)) else $error("frequency select not applied");
    tune_copy_a: assert property (regWrite && regAddr == `OSC_ADDR_TUNE |->
        ##2 tuneValue == $past(wrTune, 2)) else $error("tune value not applied");
    reset_src_a: assert property ($rose(rstn) |-> clockSource == 2'h2)
        else $error("clock source not internal in reset");
    sleep_enter_a: assert property (sleepEnter && !wakeUp |=> sleeping)
        else $error("sleep not entered");
    irq_masked_a: assert property (maskCopy_r == 2'h0 |-> !irq)
        else $error("interrupt raised while fully masked");
    extclk_direct_a: assert property ($rose(rstn) && (configuredMode == `OSC_MODE_EXTCLK ||
        configuredMode[2:1] == 2'h3) |-> ##[1:4] clockSource == 2'h0) else $error("start-up timer not skipped");
endmodule
bind osc_ctl_top osc_ctl_properties u_props (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .configuredMode(configuredMode), .sleepEnter(sleepEnter),
    .wakeUp(wakeUp), .sleeping(sleeping), .clockSource(clockSource), .clockFromHighFreq(clockFromHighFreq),
    .internalFrequency(internalFrequency), .tuneValue(tuneValue), .irq(irq));
`default_nettype wire

// File: dv/osc_ctl_tb_top.sv
// self-checking bench for the oscillator control block
// assumes osc_ctl_top from rtl/ with its checker bound beside it
`timescale 1ns/1ns
`default_nettype none
`include "osc_ctl_map.vh"
module osc_ctl_tb_top;
    logic       sys_clk, rstn, regWrite, regRead, failSafeEnable, twoSpeedEnable, configPllEnable;
    logic       sleepEnter, wakeUp, timerOscEnable, extOscPin, lowFreqOscPin, timerOscPin;
    logic       extRun, lowRun, timRun, div, sleeping, clockFromHighFreq, pllEnable, irq;
    logic [2:0] regAddr, configuredMode;
    logic [7:0] regWdata, regRdata;
    logic [5:0] readyPins, tuneValue;
    logic [3:0] internalFrequency;
    logic [1:0] clockSource;
    int         num_errors, n_tests, c;
    osc_ctl_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .configuredMode(configuredMode),
        .failSafeEnable(failSafeEnable), .twoSpeedEnable(twoSpeedEnable), .configPllEnable(configPllEnable),
        .sleepEnter(sleepEnter), .wakeUp(wakeUp), .timerOscEnable(timerOscEnable), .extOscPin(extOscPin),
        .lowFreqOscPin(lowFreqOscPin), .timerOscPin(timerOscPin), .highFreqReadyPin(readyPins[4]),
        .highFreqLockedPin(readyPins[3]), .highFreqStablePin(readyPins[0]), .mediumFreqReadyPin(readyPins[2]),
        .lowFreqReadyPin(readyPins[1]), .pllLockedPin(readyPins[5]), .sleeping(sleeping),
        .clockSource(clockSource), .clockFromHighFreq(clockFromHighFreq), .internalFrequency(internalFrequency),
        .pllEnable(pllEnable), .tuneValue(tuneValue), .irq(irq));
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // oscillator pins toggle every 2 cycles so the synchronisers see every edge
    always @(posedge sys_clk) begin
        div <= ~div;
        if (div) begin
            if (extRun) extOscPin <= ~extOscPin;
            if (lowRun) lowFreqOscPin <= ~lowFreqOscPin;
            if (timRun) timerOscPin <= ~timerOscPin;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk) begin regAddr <= a; regWdata <= d; regWrite <= 1'b1; end
        @(posedge sys_clk) regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m, input string n);
        @(posedge sys_clk) begin regAddr <= a; regRead <= 1'b1; end
        @(posedge sys_clk) regRead <= 1'b0;
        #1 chk(n, e, regRdata & m);
    endtask
    task automatic wsrc(input logic [1:0] v, input int lim, input string n);
        int i;
        for (i = 0; i < lim && clockSource !== v; i++) tick(1);
        chk(n, {6'h00, v}, {6'h00, clockSource});
    endtask
    task automatic reset_dut(input logic [2:0] mode);
        @(posedge sys_clk) begin rstn <= 1'b0; configuredMode <= mode; end
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rstn, regAddr, regWdata, regWrite, regRead, sleepEnter, wakeUp, timerOscEnable} = 0;
        {twoSpeedEnable, configPllEnable, extOscPin, lowFreqOscPin, timerOscPin, div} = 0;
        {extRun, timRun, readyPins, num_errors, n_tests} = 0;
        configuredMode = `OSC_MODE_XT;
        failSafeEnable = 1'b1;
        lowRun = 1'b1;
        reset_dut(`OSC_MODE_XT);
        rd(`OSC_ADDR_CONTROL, 8'h38, 8'hFF, "control reset");
        rd(`OSC_ADDR_IRQ_MASK, 8'h00, 8'hFF, "mask reset");
        tick(1000);
        chk("src counting", 8'h02, {6'h00, clockSource});
        rd(`OSC_ADDR_IRQ_STAT, 8'h00, 8'h01, "no fail counting");
        extRun <= 1'b1;
        tick(4060);
        chk("src early", 8'h02, {6'h00, clockSource});
        wsrc(2'h0, 200, "src after timer");
        rd(`OSC_ADDR_STATUS, 8'h20, 8'h20, "on configured");
        rd(`OSC_ADDR_IRQ_STAT, 8'h02, 8'h02, "switch flag");
        wr(`OSC_ADDR_IRQ_STAT, 8'h02);
        rd(`OSC_ADDR_IRQ_STAT, 8'h00, 8'h02, "switch cleared");
        wr(`OSC_ADDR_IRQ_MASK, 8'h01);
        extRun <= 1'b0;
        wsrc(2'h2, 700, "src on fail");
        chk("irq fail", 8'h01, {7'h00, irq});
        rd(`OSC_ADDR_IRQ_STAT, 8'h01, 8'h01, "fail flag");
        wr(`OSC_ADDR_IRQ_MASK, 8'h00);
        tick(1);
        chk("irq masked", 8'h00, {7'h00, irq});
        extRun <= 1'b1;
        wr(`OSC_ADDR_CONTROL, 8'h3A);
        tick(3);
        chk("src internal", 8'h02, {6'h00, clockSource});
        wr(`OSC_ADDR_CONTROL, 8'h38);
        tick(2000);
        chk("src restart", 8'h02, {6'h00, clockSource});
        wsrc(2'h0, 2400, "src recovered");
        for (c = 0; c < 16; c++) begin
            wr(`OSC_ADDR_CONTROL, {c[0], c[3:0], 3'b110});
            tick(2);
            chk("high source", {7'h00, c == 1 || c == 3 || c >= 8}, {7'h00, clockFromHighFreq});
            chk("pll", {7'h00, c[0]}, {7'h00, pllEnable});
            rd(`OSC_ADDR_CONTROL, {c[0], c[3:0], 3'b010}, 8'hFF, "control");
        end
        wr(`OSC_ADDR_TUNE, 8'hFF);
        rd(`OSC_ADDR_TUNE, 8'h3F, 8'hFF, "tune");
        for (c = 5; c < 8; c++) begin
            wr(c[2:0], 8'hFF);
            rd(c[2:0], 8'h00, 8'hFF, "unmapped");
        end
        // pll requested by control bit 7 here, so its lock shows in bit 6
        @(posedge sys_clk) readyPins <= 6'h35;
        tick(5);
        rd(`OSC_ADDR_STATUS, 8'h55, 8'h7F, "ready flags");
        @(posedge sys_clk) readyPins <= 6'h0A;
        tick(5);
        rd(`OSC_ADDR_STATUS, 8'h0A, 8'h7F, "ready flags");
        @(posedge sys_clk) timerOscEnable <= 1'b1;
        timRun <= 1'b1;
        wr(`OSC_ADDR_CONTROL, 8'h39);
        wsrc(2'h1, 4400, "src timer osc");
        wr(`OSC_ADDR_CONTROL, 8'h38);
        @(posedge sys_clk) sleepEnter <= 1'b1;
        @(posedge sys_clk) begin sleepEnter <= 1'b0; failSafeEnable <= 1'b0; end
        tick(2);
        chk("sleeping", 8'h01, {7'h00, sleeping});
        @(posedge sys_clk) wakeUp <= 1'b1;
        @(posedge sys_clk) wakeUp <= 1'b0;
        tick(5);
        chk("awake", 8'h00, {7'h00, sleeping});
        chk("src stalled", 8'h00, {6'h00, clockSource});
        rd(`OSC_ADDR_STATUS, 8'h00, 8'h20, "restarted");
        @(posedge sys_clk) twoSpeedEnable <= 1'b1;
        tick(3);
        chk("src two-speed cfg", 8'h02, {6'h00, clockSource});
        @(posedge sys_clk) twoSpeedEnable <= 1'b0;
        tick(3);
        chk("src stalled again", 8'h00, {6'h00, clockSource});
        @(posedge sys_clk) failSafeEnable <= 1'b1;
        tick(3);
        chk("src two-speed", 8'h02, {6'h00, clockSource});
        @(posedge sys_clk) configPllEnable <= 1'b1;
        tick(3);
        chk("pll config", 8'h01, {7'h00, pllEnable});
        for (c = 0; c < 3; c++) begin
            reset_dut(c == 0 ? `OSC_MODE_EXTCLK : 3'(5 + c));
            tick(5);
            chk("src no timer", 8'h00, {6'h00, clockSource});
        end
        give_verdict();
    end
endmodule
`default_nettype wire
